// *** pmt_program_memory.sv ***
`timescale 1ns/100ps
`include "pmt_map.svh"

module pmt_program_memory (
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Core program counter control
   input wire logic pc_load_i,
   input wire logic [11:0] pc_load_addr_i,
   input wire logic pc_hold_i,
   // Table read request, sampled at T4
   input wire logic tab_req_i,
   input wire logic tab_last_page_i,
   input wire logic tab_extended_i,
   input wire logic [7:0] tab_ptr_low_i,
   input wire logic [7:0] tab_ptr_high_i,
   input wire logic [7:0] tab_dest_i,
   // Software access to the holding register
   input wire logic tbh_wr_i,
   input wire logic [7:0] tbh_wdata_i,
   // Preload port used by the programming path
   input wire logic prog_we_i,
   input wire logic [11:0] prog_addr_i,
   input wire logic [15:0] prog_wdata_i,
   // Shared programming / debug pins
   input wire logic program_link_data_i,
   output logic program_link_data_o,
   output logic program_link_data_oe_o,
   input wire logic program_link_clock_i,
   input wire logic debug_link_data_i,
   output logic debug_link_data_o,
   output logic debug_link_data_oe_o,
   input wire logic debug_link_clock_i,
   input wire logic link_read_req_i,
   // Outputs to the core
   output logic [11:0] pc_o,
   output logic [15:0] instr_o,
   output logic instr_valid_o,
   output logic [3:0] phase_o,
   output logic tab_busy_o,
   output logic tab_done_o,
   output logic [7:0] tab_dest_o,
   output logic [7:0] tab_data_low_o,
   output logic [7:0] table_high_holding_o
);
   logic [15:0] mem [0:`PMT_WORDS-1];
   pmt_pkg::pmt_phase_t phase;
   pmt_pkg::pmt_tstate_t tstate_q;
   pmt_pkg::pmt_tstate_t tstate_d;
   logic [11:0] pc_q;
   logic [11:0] pc_d;
   logic [11:0] tab_addr_q;
   logic [7:0] dest_q;
   logic [15:0] instr_q;
   logic ivalid_q;
   logic [15:0] tword_q;
   logic [7:0] tbh_q;
   logic [7:0] tlow_q;
   logic done_q;
   logic busy_q;
   logic [15:0] link_word_q;
   logic pdat_q;
   logic poe_q;
   logic ddat_q;
   logic doe_q;
   logic [3:0] link_bit_q;
   logic clk_p_meta_q;
   logic clk_p_q;
   logic clk_p_old_q;
   logic clk_d_meta_q;
   logic clk_d_q;
   logic clk_d_old_q;

   // Phase generator
   pmt_phase_gen u_phase (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .phase_o(phase)
   );

   wire at_t1 = phase[0];
   wire at_t2 = phase[1];
   wire at_t4 = phase[3];
   wire start_tab = at_t4 && tab_req_i && (tstate_q == pmt_pkg::PMT_IDLE);
   // Full address joins the low nibble of the pointer high byte to the low byte; sector chosen by the caller
   wire [11:0] full_addr = {tab_ptr_high_i[3:0], tab_ptr_low_i};
   // Last page fixes the upper nibble and ignores the pointer high byte
   wire [11:0] last_addr = {`PMT_LAST_PAGE, tab_ptr_low_i};
   wire [11:0] sel_addr = tab_last_page_i ? last_addr : full_addr;
   wire tab_active = (tstate_q != pmt_pkg::PMT_IDLE);
   wire tab_fetch = (tstate_q == pmt_pkg::PMT_RD1) && at_t2;
   wire tab_finish = (tstate_q == pmt_pkg::PMT_RD2) && at_t4;
   // Extended forms reach every sector; plain forms use the same path
   wire ext_unused = tab_extended_i;
   wire clk_p_rise = clk_p_q && !clk_p_old_q;
   wire clk_d_rise = clk_d_q && !clk_d_old_q;
   wire link_rise = clk_p_rise || clk_d_rise;

   // Counter advances at the end of T1 unless pc_hold_i or a table read holds it
   assign pc_d = pc_load_i ? pc_load_addr_i : 12'(pc_q + 12'h001);

   // Table sequencer: two full instruction cycles
   always_comb begin
      tstate_d = tstate_q;
      unique case (tstate_q)
         pmt_pkg::PMT_IDLE: begin
            if (start_tab) begin
               tstate_d = pmt_pkg::PMT_RD1;
            end
         end
         pmt_pkg::PMT_RD1: begin
            if (at_t4) begin
               tstate_d = pmt_pkg::PMT_RD2;
            end
         end
         pmt_pkg::PMT_RD2: begin
            if (at_t4) begin
               tstate_d = pmt_pkg::PMT_IDLE;
            end
         end
         default: tstate_d = pmt_pkg::PMT_IDLE;
      endcase
   end

   // Store write from the programming preload port
   always_ff @(posedge clk_i) begin
      if (prog_we_i) begin
         mem[prog_addr_i] <= prog_wdata_i;
      end
   end

   // Instruction fetch at T1, addressed by the counter
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pc_q <= `PMT_RESET_VEC;
         instr_q <= 16'h0000;
         ivalid_q <= 1'b0;
      end else if (at_t1 && !pc_hold_i && !tab_active) begin
         instr_q <= mem[pc_q];
         ivalid_q <= 1'b1;
         pc_q <= pc_d;
      end else begin
         ivalid_q <= 1'b0;
      end
   end

   // Table request capture and single word fetch
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tstate_q <= pmt_pkg::PMT_IDLE;
         busy_q <= 1'b0;
         tab_addr_q <= 12'h000;
         dest_q <= 8'h00;
         tword_q <= 16'h0000;
      end else begin
         tstate_q <= tstate_d;
         // Busy comes from its own flop so the port is glitch free
         busy_q <= (tstate_d != pmt_pkg::PMT_IDLE);
         if (start_tab) begin
            tab_addr_q <= sel_addr;
            dest_q <= tab_dest_i;
         end
         if (tab_fetch) begin
            tword_q <= mem[tab_addr_q];
         end
      end
   end

   // Both bytes land together from one word; finish beats a software write
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tbh_q <= `PMT_TBH_RST;
         tlow_q <= 8'h00;
         done_q <= 1'b0;
      end else begin
         done_q <= tab_finish;
         if (tab_finish) begin
            tlow_q <= tword_q[7:0];
            tbh_q <= tword_q[15:8];
         end else if (tbh_wr_i) begin
            tbh_q <= tbh_wdata_i;
         end
      end
   end

   // Link clocks are ordinary synchronous inputs, two stages then edge detect
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_p_meta_q <= 1'b0;
         clk_p_q <= 1'b0;
         clk_p_old_q <= 1'b0;
         clk_d_meta_q <= 1'b0;
         clk_d_q <= 1'b0;
         clk_d_old_q <= 1'b0;
      end else begin
         clk_p_meta_q <= program_link_clock_i;
         clk_p_q <= clk_p_meta_q;
         clk_p_old_q <= clk_p_q;
         clk_d_meta_q <= debug_link_clock_i;
         clk_d_q <= clk_d_meta_q;
         clk_d_old_q <= clk_d_q;
      end
   end

   // Serial read-back of the word at the preload address, MSB first
   // Only the pin roles are modelled; the framing protocol lives elsewhere
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         link_word_q <= 16'h0000;
         link_bit_q <= 4'h0;
         pdat_q <= 1'b0;
         poe_q <= 1'b0;
         ddat_q <= 1'b0;
         doe_q <= 1'b0;
      end else if (!link_read_req_i) begin
         poe_q <= 1'b0;
         doe_q <= 1'b0;
         link_bit_q <= 4'h0;
         link_word_q <= mem[prog_addr_i];
      end else if (link_rise) begin
         pdat_q <= link_word_q[15];
         ddat_q <= link_word_q[15];
         poe_q <= clk_p_rise;
         doe_q <= clk_d_rise;
         link_word_q <= {link_word_q[14:0], program_link_data_i ^ debug_link_data_i};
         link_bit_q <= 4'(link_bit_q + 4'h1);
      end
   end

   assign pc_o = pc_q;
   assign instr_o = instr_q;
   assign instr_valid_o = ivalid_q;
   assign phase_o = phase;
   assign tab_busy_o = busy_q;
   assign tab_done_o = done_q;
   assign tab_dest_o = dest_q;
   assign tab_data_low_o = tlow_q;
   assign table_high_holding_o = tbh_q;
   assign program_link_data_o = pdat_q;
   assign program_link_data_oe_o = poe_q;
   assign debug_link_data_o = ddat_q;
   assign debug_link_data_oe_o = doe_q;
endmodule : pmt_program_memory

// *** pmt_map.svh ***
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH

// Store geometry
`define PMT_WORDS 4096
`define PMT_AW 12
`define PMT_DW 16
// Reset entry point
`define PMT_RESET_VEC 12'h000
// Base of the last 256-word page
`define PMT_LAST_PAGE 4'hF
// Table high holding reset value
`define PMT_TBH_RST 8'h00
// Phases per instruction cycle
`define PMT_PHASES 4

`endif

// *** pmt_pkg.sv ***
package pmt_pkg;
   // Instruction cycle phases, one-hot
   typedef enum logic [3:0] {
      PMT_T1 = 4'b0001,
      PMT_T2 = 4'b0010,
      PMT_T3 = 4'b0100,
      PMT_T4 = 4'b1000
   } pmt_phase_t;
   // Table read sequencer, one-hot
   typedef enum logic [2:0] {
      PMT_IDLE = 3'b001,
      PMT_RD1 = 3'b010,
      PMT_RD2 = 3'b100
   } pmt_tstate_t;
endpackage : pmt_pkg

// *** pmt_phase_gen.sv ***
`timescale 1ns/100ps
`include "pmt_map.svh"

// Four non-overlapping phases from the core clock
module pmt_phase_gen (
   input wire logic clk_i,
   input wire logic rst_n_i,
   output pmt_pkg::pmt_phase_t phase_o
);
   pmt_pkg::pmt_phase_t phase_q;
   pmt_pkg::pmt_phase_t phase_d;

   // Rotate one hot bit, T4 wraps to T1
   assign phase_d = pmt_pkg::pmt_phase_t'({phase_q[2:0], phase_q[3]});
   assign phase_o = phase_q;

   // Phase ring restarts at T1
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_q <= pmt_pkg::PMT_T1;
      end else begin
         phase_q <= phase_d;
      end
   end
endmodule : pmt_phase_gen

// *** pmt_checker.sv ***
`timescale 1ns/100ps

// Watches the top ports; all timing is in core clock cycles
module pmt_checker (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic tbh_wr_i,
   input wire logic link_read_req_i,
   input wire logic program_link_data_oe_o,
   input wire logic debug_link_data_oe_o,
   input wire logic instr_valid_o,
   input wire logic [3:0] phase_o,
   input wire logic tab_busy_o,
   input wire logic tab_done_o,
   input wire logic [7:0] tab_data_low_o,
   input wire logic [7:0] table_high_holding_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Phase rotation and fetch spacing
   property p_phase;
      phase_o == 4'b0001 |=> phase_o == 4'b0010 ##1 phase_o == 4'b0100 ##1 phase_o == 4'b1000;
   endproperty
   a_phase: assert property (p_phase) else $error("phase order broken");
   property p_gap;
      instr_valid_o |=> !instr_valid_o [*3];
   endproperty
   a_gap: assert property (p_gap) else $error("fetches too close");
   property p_nofetch;
      instr_valid_o |-> !$past(tab_busy_o);
   endproperty
   a_nofetch: assert property (p_nofetch) else $error("fetch while busy");
   // Table read length and completion
   property p_busy;
      $rose(tab_busy_o) |-> tab_busy_o [*8];
   endproperty
   a_busy: assert property (p_busy) else $error("busy too short");
   property p_pulse;
      tab_done_o |=> !tab_done_o;
   endproperty
   a_pulse: assert property (p_pulse) else $error("done not a pulse");
   property p_done;
      $fell(tab_busy_o) |-> ##[0:1] tab_done_o;
   endproperty
   a_done: assert property (p_done) else $error("done missing");
   // Result bytes move only with a table finish or a software write
   property p_low;
      $changed(tab_data_low_o) |-> tab_done_o;
   endproperty
   a_low: assert property (p_low) else $error("low byte moved");
   property p_high;
      $changed(table_high_holding_o) |-> $past(tbh_wr_i) || tab_done_o;
   endproperty
   a_high: assert property (p_high) else $error("high byte moved");
   property p_link;
      !link_read_req_i [*3] |-> !program_link_data_oe_o && !debug_link_data_oe_o;
   endproperty
   a_link: assert property (p_link) else $error("link pin driven");
endmodule : pmt_checker

// *** pmt_core_model.sv ***
`timescale 1ns/100ps

// Core side: holds a table request until the T4 edge takes it
module pmt_core_model (
   input wire logic clk_i,
   input wire logic [3:0] phase_i,
   input wire logic busy_i,
   input wire logic go_i,
   output logic tab_req_o,
   output logic taken_o
);
   initial tab_req_o = 1'b0;
   // Taken only at T4 while idle, as the sequencer samples
   assign taken_o = tab_req_o && phase_i == 4'b1000 && !busy_i;
   // Request released just after the taking edge
   always @(posedge clk_i) begin
      tab_req_o <= #1 go_i && !taken_o;
   end
endmodule : pmt_core_model

// *** program_memory_table_read_tb_top.sv ***
`timescale 1ns/100ps
`include "pmt_map.svh"

module program_memory_table_read_tb_top;
   logic clk_i = 0, rst_n_i = 0, pc_hold = 1, go = 0, lp = 0, ext = 0, tbh_wr = 0;
   logic prog_we = 0, lreq = 0, pck = 0, dck = 0;
   logic [7:0] lo = 0, hi = 0, dst = 0, tbh_wd = 0;
   logic [11:0] paddr = 0, a;
   logic [15:0] pwd = 0;
   logic [31:0] rs = 32'h0000_5a35;
   wire logic req, taken, pd, poe, dd, doe, vld, busy, done;
   wire logic [11:0] pc;
   wire logic [15:0] ins;
   wire logic [3:0] ph;
   wire logic [7:0] dsto, dlo, tbh;
   // Released pins float high through a pull-up
   wire logic pw = poe ? pd : 1'b1;
   wire logic dw = doe ? dd : 1'b1;
   logic [15:0] mem [int];
   int fails = 0, comparisons = 0, cyc = 0, n, k;

   initial forever #2.5 clk_i = !clk_i;

   pmt_program_memory i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .pc_load_i(1'b0),
      .pc_load_addr_i(12'h000), .pc_hold_i(pc_hold), .tab_req_i(req), .tab_last_page_i(lp),
      .tab_extended_i(ext), .tab_ptr_low_i(lo), .tab_ptr_high_i(hi), .tab_dest_i(dst),
      .tbh_wr_i(tbh_wr), .tbh_wdata_i(tbh_wd), .prog_we_i(prog_we), .prog_addr_i(paddr),
      .prog_wdata_i(pwd), .program_link_data_i(pw), .program_link_data_o(pd),
      .program_link_data_oe_o(poe), .program_link_clock_i(pck), .debug_link_data_i(dw),
      .debug_link_data_o(dd), .debug_link_data_oe_o(doe), .debug_link_clock_i(dck),
      .link_read_req_i(lreq), .pc_o(pc), .instr_o(ins), .instr_valid_o(vld), .phase_o(ph),
      .tab_busy_o(busy), .tab_done_o(done), .tab_dest_o(dsto), .tab_data_low_o(dlo),
      .table_high_holding_o(tbh));
   pmt_core_model i_core (.clk_i(clk_i), .phase_i(ph), .busy_i(busy), .go_i(go),
      .tab_req_o(req), .taken_o(taken));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic summarize();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize

   // Store preload, mirrored in the reference array
   task automatic pre(input logic [11:0] ad, input logic [15:0] d);
      @(posedge clk_i) #1 prog_we = 1;
      paddr = ad;
      pwd = d;
      mem[ad] = d;
      @(posedge clk_i) #1 prog_we = 0;
   endtask : pre

   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask : tick

   // Hang guard
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         summarize();
      end
   end

   initial begin
      repeat (10) @(posedge clk_i);
      #1 rst_n_i = 1;
      for (n = 0; n < 8; n++) begin
         rs = xs(rs);
         pre(n, rs[15:0]);
      end
      // Second reset: fetching restarts at word zero
      rst_n_i = 0;
      tick();
      pc_hold = 0;
      rst_n_i = 1;
      for (n = 0; n < 4; n++) begin
         do tick(); while (vld !== 1'b1);
         chk(ins, mem[n]);
         chk(pc, n + 1);
      end
      $display("fetch test done");
      // Table reads over plain, extended and last-page forms
      for (n = 0; n < 8; n++) begin
         rs = xs(rs);
         lp = n[0];
         ext = n[1];
         {dst, hi, lo} = rs[23:0];
         a = lp ? {4'hF, lo} : {hi[3:0], lo};
         rs = xs(rs);
         pre(a, rs[15:0]);
         go = 1;
         @(posedge clk_i iff taken);
         #1 go = 0;
         k = 0;
         do begin
            tick();
            k++;
         end while (done !== 1'b1 && k < 20);
         chk(16'(k), 16'(2 * `PMT_PHASES));
         chk(dlo, mem[a][7:0]);
         chk(tbh, mem[a][15:8]);
         chk(dsto, dst);
      end
      $display("table test done");
      tick();
      tbh_wr = 1;
      tbh_wd = rs[31:24];
      tick();
      tbh_wr = 0;
      chk(tbh, tbh_wd);
      $display("holding write test done");
      // Serial read-back on the programming pin, then the debug pin, MSB first
      // Address is settled before the request so the idle reload sees it
      paddr = a;
      for (k = 0; k < 2; k++) begin
         tick();
         lreq = 1;
         for (n = 15; n >= 0; n--) begin
            pck = (k == 0);
            dck = (k == 1);
            repeat (6) tick();
            if (k == 0) chk({poe, pw}, {1'b1, mem[a][n]});
            else chk({doe, dw}, {1'b1, mem[a][n]});
            chk(k ? poe : doe, 1'b0);
            pck = 0;
            dck = 0;
            repeat (6) tick();
         end
         lreq = 0;
         repeat (4) tick();
         chk({poe, doe}, 0);
      end
      $display("link test done");
      summarize();
   end
endmodule : program_memory_table_read_tb_top

bind pmt_program_memory pmt_checker i_chk (
   .clk_i(clk_i),
   .rst_n_i(rst_n_i),
   .tbh_wr_i(tbh_wr_i),
   .link_read_req_i(link_read_req_i),
   .program_link_data_oe_o(program_link_data_oe_o),
   .debug_link_data_oe_o(debug_link_data_oe_o),
   .instr_valid_o(instr_valid_o),
   .phase_o(phase_o),
   .tab_busy_o(tab_busy_o),
   .tab_done_o(tab_done_o),
   .tab_data_low_o(tab_data_low_o),
   .table_high_holding_o(table_high_holding_o)
);
